/* src/rid_core.sv */
`timescale 1ns/1ps
module rid_core (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	// Program memory
	input wire logic [11:0] instrWord,
	output logic [8:0] progAddr,
	// File registers
	output logic [4:0] fileAddr,
	input wire logic [7:0] fileRdData,
	output logic fileWrEn,
	output logic [7:0] fileWrData,
	// Port pins
	input wire logic [7:0] pinIn,
	output logic [7:0] pinDirOff,
	// Core state
	output logic [7:0] accOut,
	output logic carryFlag,
	output logic halfCarryFlag,
	output logic zeroFlag,
	output logic expiryFlag,
	output logic lowPowerFlag,
	output logic [7:0] optionOut,
	// Side effects
	output logic prescalerClr,
	output logic wdtRestart,
	output logic standbyReq
);
	typedef struct packed {
		rid_pkg::rid_phase_t phase;
		logic [11:0] ir;
		logic [8:0] pc;
		logic [8:0] stk0;
		logic [8:0] stk1;
		logic [7:0] acc;
		logic carry;
		logic halfCarry;
		logic zero;
		logic expiry;
		logic lowPower;
		logic [7:0] dir;
		logic [7:0] option;
		logic flush;
		logic fileWrEn;
		logic [7:0] fileWrData;
		logic presClr;
		logic wdtRestart;
		logic standby;
		logic [7:0] pinS1;
		logic [7:0] pinS2;
		logic [7:0] pinS3;
		logic [7:0] pinStable;
	} rid_state_t;

	rid_state_t st_q;
	rid_state_t st_d;
	logic [7:0] fOp;

	// Port reads see pin levels
	assign fOp = (st_q.ir[4:0] == rid_pkg::PORT_ADDR) ? st_q.pinStable
		: fileRdData;

	always_comb begin
		logic [7:0] res;
		logic [8:0] sum9;
		logic [4:0] lo5;
		logic wr;
		logic toFile;
		logic skip;
		logic jump;
		logic [7:0] k;
		logic [2:0] bsel;
		res = 8'h00;
		sum9 = 9'h000;
		lo5 = 5'h00;
		wr = 1'b0;
		toFile = st_q.ir[5];
		skip = 1'b0;
		jump = 1'b0;
		k = st_q.ir[7:0];
		bsel = st_q.ir[7:5];
		st_d = st_q;
		if (ce) begin
			st_d.fileWrEn = 1'b0;
			st_d.presClr = 1'b0;
			st_d.wdtRestart = 1'b0;
			st_d.standby = 1'b0;
			st_d.pinS1 = pinIn;
			st_d.pinS2 = st_q.pinS1;
			st_d.pinS3 = st_q.pinS2;
			if (st_q.pinS2 == st_q.pinS3) begin
				st_d.pinStable = st_q.pinS3;
			end
			case (st_q.phase)
				rid_pkg::PH_FETCH: begin
					if (st_q.flush) begin
						st_d.ir = rid_pkg::NOP_WORD;
						st_d.flush = 1'b0;
					end else begin
						st_d.ir = instrWord;
						st_d.pc = st_q.pc + 9'h001;
					end
					st_d.phase = rid_pkg::PH_READ;
				end
				rid_pkg::PH_READ: st_d.phase = rid_pkg::PH_OPER;
				rid_pkg::PH_OPER: st_d.phase = rid_pkg::PH_EXEC;
				rid_pkg::PH_EXEC: begin
					st_d.phase = rid_pkg::PH_FETCH;
					if (st_q.ir[11:10] == 2'b00) begin
						wr = 1'b1;
						case (st_q.ir[11:6])
							rid_pkg::OP_SPEC: begin
								if (st_q.ir[5]) begin
									res = st_q.acc;
								end else begin
									wr = 1'b0;
									case (st_q.ir[4:0])
										rid_pkg::SP_OPTION: st_d.option = st_q.acc;
										rid_pkg::SP_STANDBY: begin
											st_d.expiry = 1'b1;
											st_d.lowPower = 1'b0;
											st_d.standby = 1'b1;
										end
										rid_pkg::SP_WDT: begin
											st_d.expiry = 1'b1;
											st_d.lowPower = 1'b1;
											st_d.wdtRestart = 1'b1;
										end
										rid_pkg::SP_DIR: st_d.dir = st_q.acc;
										default: ;
									endcase
								end
							end
							rid_pkg::OP_CLR: begin
								res = 8'h00;
								st_d.zero = 1'b1;
							end
							rid_pkg::OP_SUB, rid_pkg::OP_ADD: begin
								if (st_q.ir[8]) begin
									sum9 = {1'b0, fOp} + {1'b0, st_q.acc};
									lo5 = {1'b0, fOp[3:0]} + {1'b0, st_q.acc[3:0]};
								end else begin
									sum9 = {1'b0, fOp} + {1'b0, ~st_q.acc} + 9'h001;
									lo5 = {1'b0, fOp[3:0]} + {1'b0, ~st_q.acc[3:0]}
										+ 5'h01;
								end
								res = sum9[7:0];
								st_d.carry = sum9[8];
								st_d.halfCarry = lo5[4];
								st_d.zero = (sum9[7:0] == 8'h00);
							end
							rid_pkg::OP_DEC, rid_pkg::OP_INC: begin
								res = st_q.ir[9] ? fOp + 8'h01 : fOp - 8'h01;
								st_d.zero = (res == 8'h00);
							end
							rid_pkg::OP_DECSZ, rid_pkg::OP_INCSZ: begin
								res = st_q.ir[8] ? fOp + 8'h01 : fOp - 8'h01;
								skip = (res == 8'h00);
							end
							rid_pkg::OP_IOR, rid_pkg::OP_AND, rid_pkg::OP_XOR,
							rid_pkg::OP_COM, rid_pkg::OP_MOV: begin
								case (st_q.ir[11:6])
									rid_pkg::OP_IOR: res = st_q.acc | fOp;
									rid_pkg::OP_AND: res = st_q.acc & fOp;
									rid_pkg::OP_XOR: res = st_q.acc ^ fOp;
									rid_pkg::OP_COM: res = ~fOp;
									default: res = fOp;
								endcase
								st_d.zero = (res == 8'h00);
							end
							rid_pkg::OP_RL: begin
								res = {fOp[6:0], st_q.carry};
								st_d.carry = fOp[7];
							end
							rid_pkg::OP_RR: begin
								res = {st_q.carry, fOp[7:1]};
								st_d.carry = fOp[0];
							end
							rid_pkg::OP_SWAP: res = {fOp[3:0], fOp[7:4]};
							default: wr = 1'b0;
						endcase
						if (st_q.ir[11:6] == rid_pkg::OP_CLR && !st_q.ir[5]) begin
							toFile = 1'b0;
						end
						if (st_q.ir[11:5] == 7'h01) begin
							toFile = 1'b1;
						end
					end else if (st_q.ir[11:10] == 2'b01) begin
						res = fOp;
						case (st_q.ir[11:8])
							rid_pkg::OP_BCLR: begin
								res[bsel] = 1'b0;
								wr = 1'b1;
							end
							rid_pkg::OP_BSET: begin
								res[bsel] = 1'b1;
								wr = 1'b1;
							end
							rid_pkg::OP_BTLOW: skip = !fOp[bsel];
							default: skip = fOp[bsel];
						endcase
						toFile = 1'b1;
					end else begin
						toFile = 1'b0;
						case (st_q.ir[11:8])
							rid_pkg::OP_RET: begin
								st_d.acc = k;
								st_d.pc = {1'b0, st_q.stk0[7:0]};
								st_d.stk0 = st_q.stk1;
								jump = 1'b1;
							end
							rid_pkg::OP_CALL: begin
								st_d.stk1 = st_q.stk0;
								st_d.stk0 = st_q.pc;
								st_d.pc = {1'b0, k};
								jump = 1'b1;
							end
							rid_pkg::OP_MOVL: st_d.acc = k;
							rid_pkg::OP_IORL, rid_pkg::OP_ANDL, rid_pkg::OP_XORL: begin
								case (st_q.ir[9:8])
									2'b01: res = st_q.acc | k;
									2'b10: res = st_q.acc & k;
									default: res = st_q.acc ^ k;
								endcase
								st_d.acc = res;
								st_d.zero = (res == 8'h00);
							end
							default: begin
								st_d.pc = st_q.ir[8:0];
								jump = 1'b1;
							end
						endcase
					end
					if (wr && toFile) begin
						st_d.fileWrEn = 1'b1;
						st_d.fileWrData = res;
						st_d.presClr = (st_q.ir[4:0] == rid_pkg::TIMER_ADDR)
							&& !st_q.option[rid_pkg::PSA_BIT];
					end else if (wr) begin
						st_d.acc = res;
					end
					if (skip) begin
						st_d.pc = {1'b0, st_q.pc[7:0] + 8'h01};
					end
					st_d.flush = skip || jump;
				end
				default: st_d.phase = rid_pkg::PH_FETCH;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.phase <= rid_pkg::PH_FETCH;
			st_q.pc <= rid_pkg::PC_RST;
			st_q.expiry <= 1'b1;
			st_q.lowPower <= 1'b1;
			st_q.dir <= rid_pkg::DIR_RST;
			st_q.option <= rid_pkg::OPT_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign progAddr = st_q.pc;
	assign fileAddr = st_q.ir[4:0];
	assign fileWrEn = st_q.fileWrEn;
	assign fileWrData = st_q.fileWrData;
	assign pinDirOff = st_q.dir;
	assign accOut = st_q.acc;
	assign carryFlag = st_q.carry;
	assign halfCarryFlag = st_q.halfCarry;
	assign zeroFlag = st_q.zero;
	assign expiryFlag = st_q.expiry;
	assign lowPowerFlag = st_q.lowPower;
	assign optionOut = st_q.option;
	assign prescalerClr = st_q.presClr;
	assign wdtRestart = st_q.wdtRestart;
	assign standbyReq = st_q.standby;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence sExec;
		st_q.phase == rid_pkg::PH_EXEC && ce;
	endsequence
	sequence sFlushFetch;
		st_q.phase == rid_pkg::PH_FETCH && ce && st_q.flush;
	endsequence

	AST_PHASE_WRAP: assert property (sExec
		|=> st_q.phase == rid_pkg::PH_FETCH) else $error("phase did not wrap");
	AST_FLUSH_NOP: assert property (sFlushFetch
		|=> st_q.ir == 12'h000 && st_q.pc == $past(st_q.pc))
		else $error("flush not nop");
	AST_ABSOLUTE_JUMP: assert property (sExec
		##0 st_q.ir[11:9] == rid_pkg::OP_JMP
		|=> st_q.pc == $past(st_q.ir[8:0]) && st_q.flush)
		else $error("jump target wrong");
	AST_CALL_BIT8: assert property (sExec
		##0 st_q.ir[11:8] == rid_pkg::OP_CALL
		|=> !st_q.pc[8] && st_q.stk0 == $past(st_q.pc))
		else $error("call wrong");
	AST_PORT_READ: assert property (sExec
		##0 (st_q.ir[11:5] == 7'h11 && st_q.ir[4:0] == rid_pkg::PORT_ADDR)
		|=> fileWrEn && fileWrData == $past(st_q.pinStable))
		else $error("port read");
	AST_DIR_LOAD: assert property (sExec ##0 st_q.ir == 12'h006
		|=> pinDirOff == $past(st_q.acc)) else $error("dir load");
	AST_PRES_CLR: assert property (fileWrEn
		&& fileAddr == rid_pkg::TIMER_ADDR && !optionOut[rid_pkg::PSA_BIT]
		|-> prescalerClr) else $error("prescaler not cleared");
	AST_CLR_ACC: assert property (sExec ##0 st_q.ir == 12'h040
		|=> accOut == 8'h00 && zeroFlag && !fileWrEn)
		else $error("zero acc wrong");
	AST_SKIP_NOP: assert property (sExec
		##0 st_q.ir[11:8] == rid_pkg::OP_BTLOW ##0 !fOp[st_q.ir[7:5]]
		|=> st_q.flush && st_q.phase == rid_pkg::PH_FETCH)
		else $error("skip not two cycles");
	AST_STANDBY: assert property (sExec ##0 st_q.ir == 12'h003
		|=> standbyReq && expiryFlag && !lowPowerFlag)
		else $error("standby flags");
endmodule : rid_core

/* inc/rid_pkg.sv */
// What this block does
// - Add and subtract update carry, half carry, zero.
// - Destination bit picks accumulator or file.
// - Logic ops touch zero; nibble exchange none.
// - Rotates go through carry, carry only.
// - Skip forms skip on zero; plain forms zero.
// - Bit clear, set, test-and-skip, no flags.
// - Literal logic sets zero; literal load none.
// - Return loads literal into accumulator, two cycles.
// - Call and jump take two; call clears bit 8.
// - Standby, watchdog restart, option load, no operation.
// - Port self-modify reads pin levels, not latch.
// - Direction load to port copies accumulator.
// - File write to timer clears its prescaler while option bit PSA_BIT is clear.
// - Store, copy, zero file and zero accumulator.
// - Four clocks per instruction cycle.
// - Taken test or branch takes two cycles.
package rid_pkg;
	localparam int PHASE_COUNT = 4;
	localparam logic [4:0] PORT_ADDR = 5'h06;
	localparam logic [4:0] TIMER_ADDR = 5'h01;
	localparam int PSA_BIT = 3;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] OPT_RST = 8'hFF;
	localparam logic [8:0] PC_RST = 9'h000;
	localparam logic [11:0] NOP_WORD = 12'h000;
	// Low five bits of the special group
	localparam logic [4:0] SP_OPTION = 5'h02;
	localparam logic [4:0] SP_STANDBY = 5'h03;
	localparam logic [4:0] SP_WDT = 5'h04;
	localparam logic [4:0] SP_DIR = 5'h06;
	// Byte group, top six bits
	localparam logic [5:0] OP_SPEC = 6'h00;
	localparam logic [5:0] OP_CLR = 6'h01;
	localparam logic [5:0] OP_SUB = 6'h02;
	localparam logic [5:0] OP_DEC = 6'h03;
	localparam logic [5:0] OP_IOR = 6'h04;
	localparam logic [5:0] OP_AND = 6'h05;
	localparam logic [5:0] OP_XOR = 6'h06;
	localparam logic [5:0] OP_ADD = 6'h07;
	localparam logic [5:0] OP_MOV = 6'h08;
	localparam logic [5:0] OP_COM = 6'h09;
	localparam logic [5:0] OP_INC = 6'h0A;
	localparam logic [5:0] OP_DECSZ = 6'h0B;
	localparam logic [5:0] OP_RR = 6'h0C;
	localparam logic [5:0] OP_RL = 6'h0D;
	localparam logic [5:0] OP_SWAP = 6'h0E;
	localparam logic [5:0] OP_INCSZ = 6'h0F;
	// Bit and literal groups, top four bits; jump, top three bits
	localparam logic [3:0] OP_BCLR = 4'h4;
	localparam logic [3:0] OP_BSET = 4'h5;
	localparam logic [3:0] OP_BTLOW = 4'h6;
	localparam logic [3:0] OP_BTHIGH = 4'h7;
	localparam logic [3:0] OP_RET = 4'h8;
	localparam logic [3:0] OP_CALL = 4'h9;
	localparam logic [3:0] OP_MOVL = 4'hC;
	localparam logic [3:0] OP_IORL = 4'hD;
	localparam logic [3:0] OP_ANDL = 4'hE;
	localparam logic [3:0] OP_XORL = 4'hF;
	localparam logic [2:0] OP_JMP = 3'h5;
	typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_OPER, PH_EXEC} rid_phase_t;
endpackage : rid_pkg

/* src/rid_dummy_none.sv */
`timescale 1ns/1ps

/* bench/rid_mem_model.sv */
`timescale 1ns/1ps
module rid_mem_model (
	// Clock and enable
	input wire logic core_clk,
	input wire logic ce,
	// Program memory
	input wire logic [8:0] progAddr,
	output logic [11:0] instrWord,
	// File registers
	input wire logic [4:0] fileAddr,
	output logic [7:0] fileRdData,
	input wire logic fileWrEn,
	input wire logic [7:0] fileWrData
);
	logic [11:0] rom [0:511];
	logic [7:0] file [0:31];

	initial begin
		for (int i = 0; i < 512; i++) begin
			rom[i] = 12'h000;
		end
		for (int i = 0; i < 32; i++) begin
			file[i] = 8'h00;
		end
		// Port latch differs from pin levels on purpose
		file[6] = 8'hFF;
	end

	assign instrWord = rom[progAddr];
	assign fileRdData = file[fileAddr];

	always @(posedge core_clk) begin
		if (ce && fileWrEn) begin
			file[fileAddr] <= fileWrData;
		end
	end
endmodule : rid_mem_model

/* bench/tb_rid_core.sv */
`timescale 1ns/1ps
module tb_rid_core;
	`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
		n_fail++; $display("unexpected %s exp %h got %h", nm, e, s); end end

	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic [7:0] pinIn = 8'h0F;
	logic [11:0] instrWord;
	logic [8:0] progAddr;
	logic [4:0] fileAddr;
	logic [7:0] fileRdData;
	logic fileWrEn;
	logic [7:0] fileWrData;
	logic [7:0] pinDirOff;
	logic [7:0] accOut;
	logic carryFlag;
	logic halfCarryFlag;
	logic zeroFlag;
	logic expiryFlag;
	logic lowPowerFlag;
	logic [7:0] optionOut;
	logic prescalerClr;
	logic wdtRestart;
	logic standbyReq;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int preCnt = 0;
	int wdtCnt = 0;
	int stbyCnt = 0;
	logic [11:0] prog [0:33] = '{12'h040, 12'hC35, 12'h02A, 12'hC0F,
		12'h1EA, 12'hE00, 12'h006, 12'hCA5, 12'h002, 12'h6EA, 12'h02B,
		12'hA10, 12'h000, 12'h000, 12'h000, 12'h000, 12'h226, 12'h021,
		12'h004, 12'h081, 12'h918, 12'h02C, 12'h34A, 12'hA1C, 12'h85C,
		12'h000, 12'h000, 12'h000, 12'h2AD, 12'h2ED, 12'h2AD, 12'h0ED,
		12'h003, 12'hA21};

	always #25 core_clk = ~core_clk;

	rid_core rid_core_i (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ce(ce),
		.instrWord(instrWord),
		.progAddr(progAddr),
		.fileAddr(fileAddr),
		.fileRdData(fileRdData),
		.fileWrEn(fileWrEn),
		.fileWrData(fileWrData),
		.pinIn(pinIn),
		.pinDirOff(pinDirOff),
		.accOut(accOut),
		.carryFlag(carryFlag),
		.halfCarryFlag(halfCarryFlag),
		.zeroFlag(zeroFlag),
		.expiryFlag(expiryFlag),
		.lowPowerFlag(lowPowerFlag),
		.optionOut(optionOut),
		.prescalerClr(prescalerClr),
		.wdtRestart(wdtRestart),
		.standbyReq(standbyReq)
	);

	rid_mem_model rid_mem_model_i (
		.core_clk(core_clk),
		.ce(ce),
		.progAddr(progAddr),
		.instrWord(instrWord),
		.fileAddr(fileAddr),
		.fileRdData(fileRdData),
		.fileWrEn(fileWrEn),
		.fileWrData(fileWrData)
	);

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// Pulses stand for one enabled edge
	always @(posedge core_clk) begin
		cyc++;
		if (ce && prescalerClr === 1'b1) begin
			preCnt++;
		end
		if (ce && wdtRestart === 1'b1) begin
			wdtCnt++;
		end
		if (ce && standbyReq === 1'b1) begin
			stbyCnt++;
		end
		if (cyc == 2000) begin
			n_fail++;
			close_out();
		end
	end

	initial begin
		// Load after the model has cleared its memory
		#1;
		for (int i = 0; i < 34; i++) begin
			rid_mem_model_i.rom[i] = prog[i];
		end
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		`CHK("progAddr", 9'h000, progAddr)
		`CHK("pinDirOff", 8'hFF, pinDirOff)
		`CHK("optionOut", 8'hFF, optionOut)
		`CHK("accOut", 8'h00, accOut)
		`CHK("expiry", 1'b1, expiryFlag)
		`CHK("lowPower", 1'b1, lowPowerFlag)
		$display("test reset done");
		repeat (3 * rid_pkg::PHASE_COUNT) @(posedge core_clk);
		ce <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("held pc", 9'h003, progAddr)
		`CHK("held acc", 8'h35, accOut)
		`CHK("held write", 1'b1, fileWrEn)
		`CHK("zero acc flag", 1'b1, zeroFlag)
		@(posedge core_clk);
		ce <= 1'b1;
		$display("test enable hold done");
		while (stbyCnt == 0) begin
			@(posedge core_clk);
		end
		repeat (8) @(posedge core_clk);
		#1;
		`CHK("file 0A", 8'h44, rid_mem_model_i.file[10])
		`CHK("skipped store", 8'h00, rid_mem_model_i.file[11])
		`CHK("return literal", 8'h5C, rid_mem_model_i.file[12])
		`CHK("count file", 8'hFF, rid_mem_model_i.file[13])
		`CHK("dir latches", 8'h00, pinDirOff)
		`CHK("option", 8'hA5, optionOut)
		`CHK("port from pins", 8'h0F, rid_mem_model_i.file[6])
		`CHK("timer file", 8'hA5, rid_mem_model_i.file[1])
		`CHK("prescaler clears", 1, preCnt)
		`CHK("wdt restarts", 1, wdtCnt)
		`CHK("standby", 1, stbyCnt)
		`CHK("rotate result", 8'h89, accOut)
		`CHK("carry", 1'b0, carryFlag)
		`CHK("half carry", 1'b1, halfCarryFlag)
		`CHK("zero", 1'b0, zeroFlag)
		`CHK("expiry", 1'b1, expiryFlag)
		`CHK("lowPower", 1'b0, lowPowerFlag)
		`CHK("pc in loop", 1'b1, progAddr >= 9'h021 && progAddr <= 9'h022)
		$display("test program done");
		close_out();
	end
endmodule : tb_rid_core
